// ---- hw/ctad_map.svh ----
// Register offsets, field codes and flag positions for the decoder
// What this block does
// RQ1: Each condition test is a logic expression of flags; one means true.
// RQ2: Condition results go to conditional program control and conditional trap.
// RQ3: Code 0000 is always true, code 0001 always false.
// RQ4: Always-false code is not offered to the conditional branch.
// RQ5: Same-value true on zero set; not-equal true on zero clear.
// RQ6: Unsigned tests 0010 to 0101 on carry and zero.
// RQ7: Tests 1000 to 1011 on overflow and negative alone.
// RQ8: Signed tests 1100 to 1111 on negative, overflow and zero.
// RQ9: Decimal add sums source, destination and extend as packed BCD.
// RQ10: Mode bit 0 is register pair; 1 is memory with predecrement.
// RQ11: Decimal add sets carry and extend on carry; zero only cleared.
// RQ12: Software sets zero before a multi-precision decimal chain.
// RQ13: Binary add of byte, word or long to the chosen destination.
// RQ14: Binary add sets N, Z, V, C from result; extend copies carry.
// RQ15: Opmodes 000-010 go to the data register, 100-110 to memory.
// RQ16: Source may use any mode; address register only word or long.
// RQ17: Destination allows only memory alterable modes.
// RQ18: Code generators pick the right add form for each destination.
// RQ19: Effective address is mode plus register; mode 111 uses register.
// RQ20: Condition evaluation is combinational on the current flags.
// RQ21: Illegal effective address is flagged to exceptions, not executed.
`ifndef CTAD_MAP_SVH
`define CTAD_MAP_SVH
`define CTAD_REG_FLAGS   8'h00
`define CTAD_REG_STATUS  8'h04
`define CTAD_REG_DBASE   3'h1
`define CTAD_REG_ABASE   3'h2
`define CTAD_FLAGS_RST   5'h00
`define CTAD_F_X         4
`define CTAD_F_N         3
`define CTAD_F_Z         2
`define CTAD_F_V         1
`define CTAD_F_C         0
`define CTAD_ST_ILL      0
`define CTAD_ST_DCARRY   1
`define CTAD_OPC_BCD     4'hC
`define CTAD_OPC_ADD     4'hD
`define CTAD_BCD_SIG     5'h10
`define CTAD_OPM_ADDR_W  3'h3
`define CTAD_OPM_ADDR_L  3'h7
`define CTAD_COND_TRUE     4'h0
`define CTAD_COND_FALSE    4'h1
`define CTAD_COND_ABOVE    4'h2
`define CTAD_COND_BELOWSM  4'h3
`define CTAD_COND_CCLR     4'h4
`define CTAD_COND_CSET     4'h5
`define CTAD_COND_NOTEQ    4'h6
`define CTAD_COND_SAME     4'h7
`define CTAD_COND_VCLR     4'h8
`define CTAD_COND_VSET     4'h9
`define CTAD_COND_POS      4'hA
`define CTAD_COND_NEG      4'hB
`define CTAD_COND_SATLEAST 4'hC
`define CTAD_COND_SBELOW   4'hD
`define CTAD_COND_SABOVE   4'hE
`define CTAD_COND_SATMOST  4'hF
`define CTAD_EA_DREG     3'h0
`define CTAD_EA_AREG     3'h1
`define CTAD_EA_EXT      3'h7
`define CTAD_EXT_ABS_W   3'h0
`define CTAD_EXT_ABS_L   3'h1
`define CTAD_EXT_PC_D16  3'h2
`define CTAD_EXT_PC_IDX  3'h3
`define CTAD_EXT_IMM     3'h4
`define CTAD_BCD_NINE    4'h9
`define CTAD_BCD_SIX     4'h6
`define CTAD_BYTE_ONE    32'h0000_0001
`endif

// ---- hw/ctad_pkg.sv ----
// Shared types for the condition and add decoder
package ctad_pkg;
    typedef enum logic [1:0] {
        CTAD_SZ_BYTE = 2'h0,
        CTAD_SZ_WORD = 2'h1,
        CTAD_SZ_LONG = 2'h2
    } ctad_size_t;
    typedef logic [4:0] ctad_flags_t;
endpackage

// ---- hw/ctad_cond_eval.sv ----
// Sixteen-way condition test on the flag register
`timescale 1ns/10ps
`include "ctad_map.svh"
module ctad_cond_eval
    import ctad_pkg::*;
(
    input  wire ctad_flags_t flags_in,
    input  wire logic [3:0]  cond_sel_in,
    input  wire logic        is_branch_in,
    output logic             cond_true_out,
    output logic             cond_avail_out
);
    logic n, z, v, c;
    assign n = flags_in[`CTAD_F_N];
    assign z = flags_in[`CTAD_F_Z];
    assign v = flags_in[`CTAD_F_V];
    assign c = flags_in[`CTAD_F_C];

    // RQ1 flag expressions, RQ20 purely combinational
    always_comb begin
        unique case (cond_sel_in)
            // RQ3 fixed outcomes
            `CTAD_COND_TRUE:     cond_true_out = 1'b1;
            `CTAD_COND_FALSE:    cond_true_out = 1'b0;
            // RQ6 unsigned tests
            `CTAD_COND_ABOVE:    cond_true_out = !c && !z;
            `CTAD_COND_BELOWSM:  cond_true_out = c || z;
            `CTAD_COND_CCLR:     cond_true_out = !c;
            `CTAD_COND_CSET:     cond_true_out = c;
            // RQ5 zero tests
            `CTAD_COND_NOTEQ:    cond_true_out = !z;
            `CTAD_COND_SAME:     cond_true_out = z;
            // RQ7 single flags
            `CTAD_COND_VCLR:     cond_true_out = !v;
            `CTAD_COND_VSET:     cond_true_out = v;
            `CTAD_COND_POS:      cond_true_out = !n;
            `CTAD_COND_NEG:      cond_true_out = n;
            // RQ8 signed tests
            `CTAD_COND_SATLEAST: cond_true_out = (n == v);
            `CTAD_COND_SBELOW:   cond_true_out = (n != v);
            `CTAD_COND_SABOVE:   cond_true_out = (n == v) && !z;
            `CTAD_COND_SATMOST:  cond_true_out = z || (n != v);
        endcase
    end

    // RQ4 branch cannot use the always-false code
    assign cond_avail_out = !(is_branch_in && cond_sel_in == `CTAD_COND_FALSE);
endmodule

// ---- hw/ctad_ea_check.sv ----
// Effective address field decode and legality per operand role
`timescale 1ns/10ps
`include "ctad_map.svh"
module ctad_ea_check
    import ctad_pkg::*;
(
    input  wire logic [2:0] mode_in,
    input  wire logic [2:0] reg_in,
    input  wire logic       is_dest_in,
    input  wire logic       is_byte_in,
    output logic            legal_out,
    output logic            is_dreg_out,
    output logic            is_areg_out
);
    logic ext_src_ok;
    logic ext_dst_ok;

    // RQ19 mode 111 picks its form from the register field
    always_comb begin
        ext_src_ok = 1'b0;
        ext_dst_ok = 1'b0;
        unique case (reg_in)
            `CTAD_EXT_ABS_W, `CTAD_EXT_ABS_L: begin
                ext_src_ok = 1'b1;
                ext_dst_ok = 1'b1;
            end
            `CTAD_EXT_PC_D16, `CTAD_EXT_PC_IDX, `CTAD_EXT_IMM:
                ext_src_ok = 1'b1;
            default: ;
        endcase
    end

    assign is_dreg_out = (mode_in == `CTAD_EA_DREG);
    assign is_areg_out = (mode_in == `CTAD_EA_AREG);

    always_comb begin
        if (mode_in == `CTAD_EA_EXT) begin
            legal_out = is_dest_in ? ext_dst_ok : ext_src_ok;
        end else if (is_dest_in) begin
            // RQ17 no register direct as destination
            legal_out = !is_dreg_out && !is_areg_out;
        end else begin
            // RQ16 address register source is word or long only
            legal_out = !(is_areg_out && is_byte_in);
        end
    end
endmodule

// ---- hw/ctad_core.sv ----
// Condition tests plus decimal and binary add execution
`timescale 1ns/10ps
`include "ctad_map.svh"
module ctad_core
    import ctad_pkg::*;
#(
    parameter int DW = 32,
    parameter int AW = 8
)(
    input  wire logic          mclk_in,
    input  wire logic          rst_b_in,
    input  wire logic          instr_valid_in,
    input  wire logic [15:0]   instr_in,
    input  wire logic [DW-1:0] src_opnd_in,
    input  wire logic [DW-1:0] dst_opnd_in,
    input  wire logic [3:0]    cond_sel_in,
    input  wire logic          cond_is_branch_in,
    input  wire logic [AW-1:0] reg_addr_in,
    input  wire logic [DW-1:0] reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic [DW-1:0]      reg_rdata_out,
    output logic               cond_true_out,
    output logic               cond_avail_out,
    output logic               done_out,
    output logic               illegal_out,
    output logic               mem_wr_out,
    output logic [DW-1:0]      mem_addr_out,
    output logic [DW-1:0]      mem_wdata_out,
    output ctad_flags_t        flags_out
);
    ctad_flags_t     flags_q, flags_d;
    logic [DW-1:0]   dreg_q [8];
    logic [DW-1:0]   dreg_d [8];
    logic [DW-1:0]   areg_q [8];
    logic [DW-1:0]   areg_d [8];
    logic [DW-1:0]   rdata_q, rdata_d, maddr_q, maddr_d, mdata_q, mdata_d;
    logic            done_q, done_d, ill_q, ill_d, mwr_q, mwr_d;
    logic            ill_seen_q, ill_seen_d, dcar_q, dcar_d;

    logic [2:0]      rx, opm, eam, ear;
    logic            is_bcd, is_add, ea_dst, ea_legal, ea_dreg, ea_areg;
    ctad_size_t      size;
    logic [DW-1:0]   src_val, op_a, op_b, sum, mask, msb, res;
    logic [DW:0]     wide;
    logic            carry, ovf, zero;
    logic [7:0]      bcd_s, bcd_d, bcd_r;
    logic [4:0]      lo, hi;
    logic            lo_c, bcd_c, bcd_mem;

    assign rx  = instr_in[11:9];
    assign opm = instr_in[8:6];
    assign eam = instr_in[5:3];
    assign ear = instr_in[2:0];
    assign size = ctad_size_t'(opm[1:0]);
    assign ea_dst = opm[2];
    assign bcd_mem = instr_in[3];
    assign is_bcd = instr_valid_in && instr_in[15:12] == `CTAD_OPC_BCD
                    && instr_in[8:4] == `CTAD_BCD_SIG;
    // Address-register forms belong to another decoder
    assign is_add = instr_valid_in && instr_in[15:12] == `CTAD_OPC_ADD
                    && opm != `CTAD_OPM_ADDR_W && opm != `CTAD_OPM_ADDR_L;

    // RQ2 condition result for branches and conditional trap
    ctad_cond_eval u_cond (
        .flags_in       (flags_q),
        .cond_sel_in    (cond_sel_in),
        .is_branch_in   (cond_is_branch_in),
        .cond_true_out  (cond_true_out),
        .cond_avail_out (cond_avail_out)
    );

    ctad_ea_check u_ea (
        .mode_in     (eam),
        .reg_in      (ear),
        .is_dest_in  (ea_dst),
        .is_byte_in  (size == CTAD_SZ_BYTE),
        .legal_out   (ea_legal),
        .is_dreg_out (ea_dreg),
        .is_areg_out (ea_areg)
    );

    // RQ13 operand selection by role
    always_comb begin
        if (ea_dreg) begin
            src_val = dreg_q[ear];
        end else if (ea_areg) begin
            src_val = areg_q[ear];
        end else begin
            src_val = src_opnd_in;
        end
        op_a = ea_dst ? dreg_q[rx] : src_val;
        op_b = ea_dst ? dst_opnd_in : dreg_q[rx];
        unique case (size)
            CTAD_SZ_BYTE: mask = 32'h0000_00FF;
            CTAD_SZ_WORD: mask = 32'h0000_FFFF;
            default:      mask = 32'hFFFF_FFFF;
        endcase
        msb  = mask ^ (mask >> 1);
        wide = {1'b0, op_a & mask} + {1'b0, op_b & mask};
        sum  = wide[DW-1:0] & mask;
        // Carry is the bit just above the operand size
        carry = |(wide[DW:1] & msb) || (size == CTAD_SZ_LONG && wide[DW]);
        if (size == CTAD_SZ_LONG) begin
            carry = wide[DW];
        end else begin
            carry = |((wide[DW-1:0] & ~mask) & (msb << 1));
        end
        ovf  = (|(op_a & msb) == |(op_b & msb)) && (|(sum & msb) != |(op_a & msb));
        zero = (sum == '0);
        res  = ea_dst ? sum : ((dreg_q[rx] & ~mask) | sum);
    end

    // RQ9 packed decimal digit adder with extend in
    always_comb begin
        bcd_s = bcd_mem ? src_opnd_in[7:0] : dreg_q[ear][7:0];
        bcd_d = bcd_mem ? dst_opnd_in[7:0] : dreg_q[rx][7:0];
        lo = {1'b0, bcd_s[3:0]} + {1'b0, bcd_d[3:0]}
             + {4'h0, flags_q[`CTAD_F_X]};
        lo_c = lo > {1'b0, `CTAD_BCD_NINE};
        if (lo_c) begin
            lo = lo + {1'b0, `CTAD_BCD_SIX};
        end
        hi = {1'b0, bcd_s[7:4]} + {1'b0, bcd_d[7:4]} + {4'h0, lo_c};
        bcd_c = hi > {1'b0, `CTAD_BCD_NINE};
        if (bcd_c) begin
            hi = hi + {1'b0, `CTAD_BCD_SIX};
        end
        bcd_r = {hi[3:0], lo[3:0]};
    end

    always_comb begin
        flags_d = flags_q;
        dreg_d = dreg_q;
        areg_d = areg_q;
        done_d = 1'b0;
        ill_d = 1'b0;
        mwr_d = 1'b0;
        maddr_d = maddr_q;
        mdata_d = mdata_q;
        dcar_d = dcar_q;
        ill_seen_d = ill_seen_q;
        rdata_d = '0;
        // Software writes come first so an instruction overrides them
        if (reg_wr_in) begin
            if (reg_addr_in == `CTAD_REG_FLAGS) begin
                flags_d = reg_wdata_in[4:0];
            end else if (reg_addr_in == `CTAD_REG_STATUS) begin
                ill_seen_d = ill_seen_q && !reg_wdata_in[`CTAD_ST_ILL];
            end else if (reg_addr_in[AW-1:5] == `CTAD_REG_DBASE) begin
                dreg_d[reg_addr_in[4:2]] = reg_wdata_in;
            end else if (reg_addr_in[AW-1:5] == `CTAD_REG_ABASE) begin
                areg_d[reg_addr_in[4:2]] = reg_wdata_in;
            end
        end
        if (is_bcd) begin
            done_d = 1'b1;
            dcar_d = bcd_c;
            // RQ11 carry and extend follow decimal carry; zero only cleared
            flags_d[`CTAD_F_C] = bcd_c;
            flags_d[`CTAD_F_X] = bcd_c;
            if (bcd_r != 8'h00) begin
                flags_d[`CTAD_F_Z] = 1'b0;
            end
            // RQ10 register pair or predecrement memory pair
            if (bcd_mem) begin
                areg_d[ear] = areg_q[ear] - `CTAD_BYTE_ONE;
                areg_d[rx] = areg_d[rx] - `CTAD_BYTE_ONE;
                maddr_d = areg_d[rx];
                mdata_d = {24'h00_0000, bcd_r};
                mwr_d = 1'b1;
            end else begin
                dreg_d[rx] = {dreg_q[rx][DW-1:8], bcd_r};
            end
        end else if (is_add && !ea_legal) begin
            // RQ21 illegal operand mode goes to exception logic
            ill_d = 1'b1;
            ill_seen_d = 1'b1;
        end else if (is_add) begin
            done_d = 1'b1;
            // RQ14 result flags, extend copies carry
            flags_d[`CTAD_F_N] = |(sum & msb);
            flags_d[`CTAD_F_Z] = zero;
            flags_d[`CTAD_F_V] = ovf;
            flags_d[`CTAD_F_C] = carry;
            flags_d[`CTAD_F_X] = carry;
            // RQ15 opmode bit two picks destination
            if (ea_dst) begin
                mdata_d = res;
                mwr_d = 1'b1;
            end else begin
                dreg_d[rx] = res;
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == `CTAD_REG_FLAGS) begin
                rdata_d = {{(DW-5){1'b0}}, flags_q};
            end else if (reg_addr_in == `CTAD_REG_STATUS) begin
                rdata_d = {{(DW-2){1'b0}}, dcar_q, ill_seen_q};
            end else if (reg_addr_in[AW-1:5] == `CTAD_REG_DBASE) begin
                rdata_d = dreg_q[reg_addr_in[4:2]];
            end else if (reg_addr_in[AW-1:5] == `CTAD_REG_ABASE) begin
                rdata_d = areg_q[reg_addr_in[4:2]];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_q <= `CTAD_FLAGS_RST;
            for (int i = 0; i < 8; i++) begin
                dreg_q[i] <= '0;
                areg_q[i] <= '0;
            end
            rdata_q <= '0;
            maddr_q <= '0;
            mdata_q <= '0;
            done_q <= 1'b0;
            ill_q <= 1'b0;
            mwr_q <= 1'b0;
            ill_seen_q <= 1'b0;
            dcar_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            dreg_q <= dreg_d;
            areg_q <= areg_d;
            rdata_q <= rdata_d;
            maddr_q <= maddr_d;
            mdata_q <= mdata_d;
            done_q <= done_d;
            ill_q <= ill_d;
            mwr_q <= mwr_d;
            ill_seen_q <= ill_seen_d;
            dcar_q <= dcar_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign done_out = done_q;
    assign illegal_out = ill_q;
    assign mem_wr_out = mwr_q;
    assign mem_addr_out = maddr_q;
    assign mem_wdata_out = mdata_q;
    assign flags_out = flags_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_add_take;
        is_add && ea_legal && !is_bcd;
    endsequence
    sequence s_bad_take;
        is_add && !ea_legal && !is_bcd;
    endsequence

    a_always_true: assert property ( // RQ3
        cond_sel_in == `CTAD_COND_TRUE |-> cond_true_out)
        else $error("always-true test gave false");
    a_always_false: assert property ( // RQ3
        cond_sel_in == `CTAD_COND_FALSE |-> !cond_true_out)
        else $error("always-false test gave true");
    a_branch_no_false: assert property ( // RQ4
        cond_is_branch_in && cond_sel_in == `CTAD_COND_FALSE
        |-> !cond_avail_out)
        else $error("always-false offered to branch");
    a_same_zero_flag: assert property ( // RQ5
        cond_sel_in == `CTAD_COND_SAME |-> cond_true_out == flags_q[`CTAD_F_Z])
        else $error("same-value test not on zero flag");
    a_signed_at_least: assert property ( // RQ8
        cond_sel_in == `CTAD_COND_SATLEAST
        |-> cond_true_out == (flags_q[`CTAD_F_N] == flags_q[`CTAD_F_V]))
        else $error("signed at-least test wrong");
    a_add_done: assert property ( // RQ13
        s_add_take ##1 1'b1 |-> done_out && !illegal_out)
        else $error("legal add did not complete");
    a_add_xcopy: assert property ( // RQ14
        s_add_take |=> flags_q[`CTAD_F_X] == flags_q[`CTAD_F_C])
        else $error("extend does not copy carry");
    a_illegal_stop: assert property ( // RQ21
        s_bad_take |=> illegal_out && !done_out && !mem_wr_out
        && $stable(flags_q))
        else $error("illegal mode was executed");
    a_dest_reject: assert property ( // RQ17
        is_add && !is_bcd && ea_dst && eam == `CTAD_EA_DREG |=> illegal_out)
        else $error("register destination not rejected");
    a_bcd_zero_keep: assert property ( // RQ11
        is_bcd && !flags_q[`CTAD_F_Z] && !reg_wr_in
        |=> !flags_q[`CTAD_F_Z] && done_out)
        else $error("decimal add set the zero flag");
    a_not_equal_zero: assert property ( // RQ5
        cond_sel_in == `CTAD_COND_NOTEQ
        |-> cond_true_out != flags_q[`CTAD_F_Z])
        else $error("not-equal test not on zero flag");
    a_unsigned_above: assert property ( // RQ6
        cond_sel_in == `CTAD_COND_ABOVE
        |-> cond_true_out == !(flags_q[`CTAD_F_C] || flags_q[`CTAD_F_Z]))
        else $error("unsigned above test wrong");
    a_overflow_set: assert property ( // RQ7
        cond_sel_in == `CTAD_COND_VSET
        |-> cond_true_out == flags_q[`CTAD_F_V])
        else $error("overflow set test not on overflow flag");
    a_bcd_xcopy: assert property ( // RQ11
        is_bcd |=> flags_q[`CTAD_F_X] == flags_q[`CTAD_F_C])
        else $error("decimal add extend differs from carry");
    a_byte_areg_src: assert property ( // RQ16
        is_add && !ea_dst && ea_areg && size == CTAD_SZ_BYTE |=> illegal_out)
        else $error("byte add from address register accepted");
endmodule

// ---- tb/ctad_pmem.sv ----
// Program memory model feeding instruction and operand words
`timescale 1ns/10ps
module ctad_pmem (
    input  wire logic        mclk_in,
    input  wire logic        stall_in,
    output logic             instr_valid_out,
    output logic [15:0]      instr_out,
    output logic [31:0]      src_opnd_out,
    output logic [31:0]      dst_opnd_out
);
    logic [79:0] fetch_q[$];

    // any instruction word is queued with its source and destination operand words
    task automatic push(input logic [15:0] w, input logic [31:0] s, d);
        fetch_q.push_back({w, s, d});
    endtask

    initial begin
        instr_valid_out = 1'b0;
        instr_out       = 16'h0000;
        src_opnd_out    = 32'h0000_0000;
        dst_opnd_out    = 32'h0000_0000;
    end

    // Idle words flip each cycle so a stale word never looks valid
    always @(posedge mclk_in) begin
        if (fetch_q.size() != 0 && !stall_in) begin
            {instr_out, src_opnd_out, dst_opnd_out} <= fetch_q.pop_front();
            instr_valid_out <= 1'b1;
        end else begin
            instr_valid_out <= 1'b0;
            instr_out       <= ~instr_out;
            src_opnd_out    <= ~src_opnd_out;
            dst_opnd_out    <= ~dst_opnd_out;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the condition and add decoder
`timescale 1ns/10ps
module tb_top;
    import ctad_pkg::*;
    logic        mclk_in, rst_b_in, stall, instr_valid_in;
    logic        cond_is_branch_in, reg_wr_in, reg_rd_in;
    logic [15:0] instr_in;
    logic [31:0] src_opnd_in, dst_opnd_in, reg_wdata_in, reg_rdata_out;
    logic [31:0] mem_addr_out, mem_wdata_out;
    logic [3:0]  cond_sel_in;
    logic [7:0]  reg_addr_in;
    logic        cond_true_out, cond_avail_out, done_out, illegal_out;
    logic        mem_wr_out, done_seen, ill_seen, mw_seen;
    ctad_flags_t flags_out;
    int          error_cnt, samples_checked;

    ctad_core #(.DW(32), .AW(8)) u_dut (
        .mclk_in, .rst_b_in, .instr_valid_in, .instr_in, .src_opnd_in,
        .dst_opnd_in, .cond_sel_in, .cond_is_branch_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .cond_true_out, .cond_avail_out, .done_out, .illegal_out,
        .mem_wr_out, .mem_addr_out, .mem_wdata_out, .flags_out
    );
    ctad_pmem u_pmem (
        .mclk_in, .stall_in(stall), .instr_valid_out(instr_valid_in),
        .instr_out(instr_in), .src_opnd_out(src_opnd_in),
        .dst_opnd_out(dst_opnd_in)
    );

    initial begin
        mclk_in = 1'b0;
        forever #2.5 mclk_in = ~mclk_in;
    end

    task automatic check(input string nm, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string nm);
        @(posedge mclk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in   <= 1'b0;
        #1;
        check(nm, reg_rdata_out, e);
    endtask

    // Waits a bounded time for the one-cycle answer pulse
    task automatic run(input logic [15:0] w, input logic [31:0] s, d);
        int k;
        u_pmem.push(w, s, d);
        for (k = 0; k < 8; k++) begin
            @(posedge mclk_in);
            #1;
            if (done_out === 1'b1 || illegal_out === 1'b1) break;
        end
        done_seen = done_out;
        ill_seen  = illegal_out;
        mw_seen   = mem_wr_out;
        check("answer_wait", 32'(k < 8), 32'h1);
    endtask

    // truth table of every condition code
    function automatic logic cc_exp(input logic [3:0] c, input logic [4:0] f);
        logic n, z, v, k;
        {n, z, v, k} = f[3:0];
        case (c)
            4'h0: return 1'b1;
            4'h1: return 1'b0;
            4'h2: return !k && !z;
            4'h3: return k || z;
            4'h4: return !k;
            4'h5: return k;
            4'h6: return !z;
            4'h7: return z;
            4'h8: return !v;
            4'h9: return v;
            4'hA: return !n;
            4'hB: return n;
            4'hC: return n == v;
            4'hD: return n != v;
            4'hE: return (n == v) && !z;
            default: return z || (n != v);
        endcase
    endfunction

    task automatic t_reset();
        check("flags_rst", 32'(flags_out), 32'h0);
        check("cond_rst", 32'(cond_true_out), 32'h1);
        rd_chk(8'h00, 32'h0, "flags_reg_rst");
        rd_chk(8'h20, 32'h0, "dreg_rst");
        reg_wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 32'h0, "unmapped");
    endtask

    task automatic t_cond();
        int f, c;
        for (f = 0; f < 32; f++) begin
            reg_wr(8'h00, 32'(f));
            for (c = 0; c < 16; c++) begin
                cond_sel_in       <= 4'(c);
                cond_is_branch_in <= f[0];
                @(posedge mclk_in);
                #1;
                check("cond", 32'(cond_true_out),
                      32'(cc_exp(4'(c), 5'(f))));
                check("avail", 32'(cond_avail_out),
                      32'(!(f[0] && c == 1)));
            end
        end
    endtask

    task automatic t_bcd();
        reg_wr(8'h20, 32'h1234_5638);
        reg_wr(8'h24, 32'h0000_0045);
        reg_wr(8'h00, 32'h0000_0015);
        run({4'hC, 3'h0, 5'h10, 1'b0, 3'h1}, 32'h0, 32'h0);
        rd_chk(8'h20, 32'h1234_5684, "bcd_reg");
        check("bcd_fl1", 32'(flags_out & 5'h15), 32'h0);
        reg_wr(8'h24, 32'h0000_0016);
        // zero preset before a chained decimal add
        reg_wr(8'h00, 32'h0000_0004);
        run({4'hC, 3'h0, 5'h10, 1'b0, 3'h1}, 32'h0, 32'h0);
        rd_chk(8'h20, 32'h1234_5600, "bcd_wrap");
        check("bcd_fl2", 32'(flags_out & 5'h15), 32'h15);
        rd_chk(8'h04, 32'h2, "status_dcar");
        reg_wr(8'h40, 32'h0000_0200);
        reg_wr(8'h44, 32'h0000_0100);
        reg_wr(8'h00, 32'h0000_0010);
        run({4'hC, 3'h0, 5'h10, 1'b1, 3'h1}, 32'h27, 32'h15);
        check("bcd_mw", 32'(mw_seen), 32'h1);
        check("bcd_maddr", mem_addr_out, 32'h1FF);
        check("bcd_mdata", 32'(mem_wdata_out[7:0]), 32'h43);
        check("bcd_fl3", 32'(flags_out & 5'h15), 32'h0);
        rd_chk(8'h44, 32'h0000_00FF, "bcd_src_dec");
        rd_chk(8'h40, 32'h0000_01FF, "bcd_dst_dec");
    endtask

    task automatic t_add();
        logic [31:0] d0v[3] = '{32'hAAAA_AAFF, 32'h1111_7FFF, 32'h8000_0000};
        logic [31:0] d1v[3] = '{32'h1, 32'h1, 32'h8000_0000};
        logic [31:0] rv[3]  = '{32'hAAAA_AA00, 32'h1111_8000, 32'h0};
        logic [31:0] fv[3]  = '{32'h15, 32'h0A, 32'h17};
        for (int i = 0; i < 3; i++) begin
            reg_wr(8'h20, d0v[i]);
            reg_wr(8'h24, d1v[i]);
            run({4'hD, 3'h0, 3'(i), 3'h0, 3'h1}, 32'h0, 32'h0);
            check("add_done", 32'(done_seen), 32'h1);
            rd_chk(8'h20, rv[i], "add_sum");
            check("add_flags", 32'(flags_out), fv[i]);
        end
        reg_wr(8'h20, 32'h0000_0010);
        run({4'hD, 3'h0, 3'h6, 3'h2, 3'h1}, 32'h0, 32'hFFFF_FFF0);
        check("addm_mw", 32'(mw_seen), 32'h1);
        check("addm_data", mem_wdata_out, 32'h0);
        check("addm_addr", mem_addr_out, 32'h1FF);
        check("addm_flags", 32'(flags_out), 32'h15);
        run({4'hD, 3'h0, 3'h1, 3'h7, 3'h4}, 32'h5, 32'h0);
        rd_chk(8'h20, 32'h0000_0015, "add_imm");
    endtask

    task automatic t_illegal();
        logic [15:0] w[8] = '{16'hD009, 16'hD049, 16'hD101, 16'hD109,
                              16'hD13C, 16'hD13A, 16'hD13B, 16'hD138};
        logic        e[8] = '{1'b1, 1'b0, 1'b1, 1'b1,
                              1'b1, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 8; i++) begin
            reg_wr(8'h00, 32'h0000_000A);
            run(w[i], 32'h1, 32'h1);
            check("ill_flag", 32'(ill_seen), 32'(e[i]));
            check("ill_done", 32'(done_seen), 32'(!e[i]));
            if (e[i]) check("ill_keep", 32'(flags_out), 32'h0A);
        end
        rd_chk(8'h04, 32'h1, "status_ill");
        reg_wr(8'h04, 32'h1);
        rd_chk(8'h04, 32'h0, "status_clr");
    endtask

    task automatic t_b2b();
        int n;
        n = 0;
        reg_wr(8'h20, 32'h1);
        reg_wr(8'h24, 32'h2);
        stall <= 1'b1;
        // Stall must be in place before the words are queued
        @(posedge mclk_in);
        u_pmem.push({4'hD, 3'h0, 3'h2, 3'h0, 3'h1}, 32'h0, 32'h0);
        u_pmem.push({4'hD, 3'h0, 3'h2, 3'h0, 3'h1}, 32'h0, 32'h0);
        repeat (3) @(posedge mclk_in);
        stall <= 1'b0;
        repeat (6) begin
            @(posedge mclk_in);
            #1;
            if (done_out === 1'b1) n++;
        end
        check("b2b_count", 32'(n), 32'h2);
        rd_chk(8'h20, 32'h5, "b2b_sum");
    endtask

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        rst_b_in = 1'b0;
        stall = 1'b0;
        cond_sel_in = 4'h0;
        cond_is_branch_in = 1'b0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        repeat (16) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        #1;
        t_reset();
        t_cond();
        t_bcd();
        t_add();
        t_illegal();
        t_b2b();
        report_and_stop();
    end

    // Whole run needs under a thousand cycles
    initial begin
        repeat (40000) @(posedge mclk_in);
        error_cnt++;
        report_and_stop();
    end
endmodule
